// ### inc/ecpsc_pkg.sv
// constants for the exception pend set/clear/status register slice
// assumes one core clock domain and a word-wide Avalon-MM register port
package ecpsc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ECPSC_ADDR_W = 12;
    localparam int ECPSC_DATA_W = 32;
    localparam int ECPSC_BE_W = 4;
    localparam logic [11:0] ECPSC_ICS_OFFSET = 12'hd04;
    localparam logic [31:0] ECPSC_ICS_RESET = 32'h0000_0000;
    localparam logic [31:0] ECPSC_UNMAPPED_RD = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions of interrupt_control_state
    // ------------------------------------------------------------
    localparam int ECPSC_DEF_SET_BIT = 28;
    localparam int ECPSC_DEF_CLR_BIT = 27;
    localparam int ECPSC_TICK_SET_BIT = 26;
    localparam int ECPSC_TICK_CLR_BIT = 25;
    localparam int ECPSC_RSV_HI_BIT = 24;
    localparam int ECPSC_HALT_IRQ_BIT = 23;
    localparam int ECPSC_ANY_PEND_BIT = 22;
    localparam int ECPSC_RSV_LO_MSB = 21;
    localparam int ECPSC_RSV_LO_LSB = 18;
    // byte lane that carries bits 31:24
    localparam int ECPSC_CTRL_LANE = 3;

    // ------------------------------------------------------------
    // pending flags
    // ------------------------------------------------------------
    localparam int ECPSC_NFLAG = 2;
    localparam int ECPSC_IDX_DEF = 0;
    localparam int ECPSC_IDX_TICK = 1;
    localparam logic ECPSC_FLAG_RST = 1'b0;
    localparam logic ECPSC_WAIT_RST = 1'b1;

    // ------------------------------------------------------------
    // bus handshake states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ECPSC_ST_IDLE = 2'b01,
        ECPSC_ST_ACK = 2'b10
    } ecpsc_bus_st_t;

endpackage : ecpsc_pkg

// ### design/ecpsc_pend_flag.sv
// one sticky pending flag with set and clear sources
// assumes all inputs are synchronous single-cycle strobes
`timescale 1ns/1ps
module ecpsc_pend_flag
    import ecpsc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // set and clear sources
    input wire logic sw_set_in,
    input wire logic hw_set_in,
    input wire logic sw_clr_in,
    input wire logic entry_clr_in,
    // state
    output logic pend_out
);

    logic pend_r;
    logic pend_nxt;

    // set is applied last so an event never gets lost to a clear
    always_comb begin
        pend_nxt = pend_r;
        if (sw_clr_in || entry_clr_in) begin
            pend_nxt = 1'b0;
        end
        if (sw_set_in || hw_set_in) begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend_r <= ECPSC_FLAG_RST;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    assign pend_out = pend_r;

endmodule : ecpsc_pend_flag

// ### design/ecpsc_status.sv
// registered debug and global pending status bits
// assumes core status inputs are synchronous levels
`timescale 1ns/1ps
module ecpsc_status
    import ecpsc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // core state
    input wire logic debug_halted_in,
    input wire logic halt_irq_ready_in,
    input wire logic ext_irq_pend_in,
    input wire logic def_pend_in,
    input wire logic tick_pend_in,
    // status
    output logic halt_irq_out,
    output logic any_pend_out
);

    logic halt_irq_r;
    logic halt_irq_nxt;
    logic any_pend_r;
    logic any_pend_nxt;

    always_comb begin
        // meaningless outside debug, so masked there
        halt_irq_nxt = debug_halted_in && halt_irq_ready_in; // [R08] [R09]
        // nmi and faults never reach ext_irq_pend_in
        any_pend_nxt = ext_irq_pend_in || def_pend_in || tick_pend_in; // [R10]
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            halt_irq_r <= 1'b0;
            any_pend_r <= 1'b0;
        end else begin
            halt_irq_r <= halt_irq_nxt;
            any_pend_r <= any_pend_nxt;
        end
    end

    assign halt_irq_out = halt_irq_r;
    assign any_pend_out = any_pend_r;

endmodule : ecpsc_status

// ### design/ecpsc_top.sv
// exception pend set/clear and status slice of the interrupt control
// and state register, with an Avalon-MM slave port
// assumes master holds a request until it samples waitrequest low
//
// Operation
// [R01] deferred_call_set_pending reads the deferred exception pending state and a written 1 makes it pending.
// [R02] only a software write of 1 can make the deferred exception pending.
// [R03] a written 1 to deferred_call_clear_pending removes the deferred pending state, a 0 does nothing.
// [R04] both clear-pending bits are write-only and their read value is not to be relied on.
// [R05] tick_set_pending reads the tick exception pending state and a written 1 makes it pending.
// [R06] writing 1 to tick_clear_pending clears the state shown by tick_set_pending.
// [R07] a written 1 to tick_clear_pending removes the tick pending state, a 0 leaves it.
// [R08] halt_release_takes_irq reads 1 when leaving debug halt will take an interrupt.
// [R09] halt_release_takes_irq reads zero whenever the core is not in debug.
// [R10] any_irq_pending reads 1 when any interrupt other than nmi or a fault is pending.
// [R11] reserved bit 24 and bits 21:18 are read-only zero.
// [R12] software must not write 1 to a set bit and its matching clear bit together.
// [R13] the pending state is cleared when the core enters that exception's handler.
`timescale 1ns/1ps
module ecpsc_top
    import ecpsc_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // avalon-mm slave
    input wire logic [ECPSC_ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [ECPSC_DATA_W-1:0] AVS_WRITEDATA_IN,
    input wire logic [ECPSC_BE_W-1:0] AVS_BYTEENABLE_IN,
    output logic [ECPSC_DATA_W-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    // core exception state
    input wire logic DEBUG_HALTED_IN,
    input wire logic HALT_IRQ_READY_IN,
    input wire logic EXT_IRQ_PEND_IN,
    input wire logic TICK_EVENT_IN,
    input wire logic DEFERRED_ENTRY_IN,
    input wire logic TICK_ENTRY_IN,
    // pending state to the core
    output logic DEFERRED_PEND_OUT,
    output logic TICK_PEND_OUT
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic ics_hit(input logic [ECPSC_ADDR_W-1:0] a);
        ics_hit = (a == ECPSC_ICS_OFFSET);
    endfunction : ics_hit

    function automatic logic [ECPSC_DATA_W-1:0] ics_word(
        input logic def_p,
        input logic tick_p,
        input logic halt_irq,
        input logic any_p
    );
        logic [ECPSC_DATA_W-1:0] w;
        w = ECPSC_ICS_RESET;
        w[ECPSC_DEF_SET_BIT] = def_p; // [R01]
        w[ECPSC_TICK_SET_BIT] = tick_p; // [R05]
        // clear bits read back as zero
        w[ECPSC_DEF_CLR_BIT] = 1'b0; // [R04]
        w[ECPSC_TICK_CLR_BIT] = 1'b0; // [R04]
        w[ECPSC_RSV_HI_BIT] = 1'b0; // [R11]
        w[ECPSC_RSV_LO_MSB:ECPSC_RSV_LO_LSB] = '0; // [R11]
        w[ECPSC_HALT_IRQ_BIT] = halt_irq; // [R08]
        w[ECPSC_ANY_PEND_BIT] = any_p; // [R10]
        ics_word = w;
    endfunction : ics_word

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    ecpsc_bus_st_t state_r;
    ecpsc_bus_st_t state_nxt;
    logic wait_r;
    logic wait_nxt;
    logic [ECPSC_DATA_W-1:0] rdata_r;
    logic [ECPSC_DATA_W-1:0] rdata_nxt;
    logic [ECPSC_NFLAG-1:0] pend_w;
    logic halt_irq_w;
    logic any_pend_w;
    logic wr_take;

    // every access costs one wait cycle; this keeps the read word a
    // plain flop and gives a fixed two-cycle answer
    always_comb begin
        state_nxt = state_r;
        wait_nxt = 1'b1;
        rdata_nxt = ECPSC_UNMAPPED_RD;
        case (state_r)
            ECPSC_ST_IDLE: begin
                if (AVS_READ_IN || AVS_WRITE_IN) begin
                    state_nxt = ECPSC_ST_ACK;
                    wait_nxt = 1'b0;
                    if (AVS_READ_IN && ics_hit(AVS_ADDRESS_IN)) begin
                        rdata_nxt = ics_word(pend_w[ECPSC_IDX_DEF],
                            pend_w[ECPSC_IDX_TICK], halt_irq_w, any_pend_w);
                    end
                end
            end
            ECPSC_ST_ACK: begin
                state_nxt = ECPSC_ST_IDLE;
                wait_nxt = 1'b1;
            end
            default: begin
                state_nxt = ECPSC_ST_IDLE;
                wait_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state_r <= ECPSC_ST_IDLE;
            wait_r <= ECPSC_WAIT_RST;
            rdata_r <= ECPSC_UNMAPPED_RD;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign AVS_WAITREQUEST_OUT = wait_r;
    assign AVS_READDATA_OUT = rdata_r;

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    // a write lands at the edge where the master sees waitrequest low;
    // unmapped writes and writes without the top lane are dropped
    assign wr_take = (state_r == ECPSC_ST_ACK) && AVS_WRITE_IN &&
        ics_hit(AVS_ADDRESS_IN) && AVS_BYTEENABLE_IN[ECPSC_CTRL_LANE];

    logic [ECPSC_NFLAG-1:0] sw_set;
    logic [ECPSC_NFLAG-1:0] sw_clr;
    logic [ECPSC_NFLAG-1:0] hw_set;
    logic [ECPSC_NFLAG-1:0] entry_clr;

    always_comb begin
        // a zero in any of these bits has no effect
        sw_set[ECPSC_IDX_DEF] = wr_take &&
            AVS_WRITEDATA_IN[ECPSC_DEF_SET_BIT]; // [R01]
        sw_clr[ECPSC_IDX_DEF] = wr_take &&
            AVS_WRITEDATA_IN[ECPSC_DEF_CLR_BIT]; // [R03]
        sw_set[ECPSC_IDX_TICK] = wr_take &&
            AVS_WRITEDATA_IN[ECPSC_TICK_SET_BIT]; // [R05]
        sw_clr[ECPSC_IDX_TICK] = wr_take &&
            AVS_WRITEDATA_IN[ECPSC_TICK_CLR_BIT]; // [R06] [R07]
        // deferred exception has no hardware source at all
        hw_set[ECPSC_IDX_DEF] = 1'b0; // [R02]
        hw_set[ECPSC_IDX_TICK] = TICK_EVENT_IN;
        entry_clr[ECPSC_IDX_DEF] = DEFERRED_ENTRY_IN; // [R13]
        entry_clr[ECPSC_IDX_TICK] = TICK_ENTRY_IN; // [R13]
    end

    // ------------------------------------------------------------
    // pending flags
    // ------------------------------------------------------------
    // set beats clear inside each flag, so a forbidden set+clear write
    // leaves the flag pending
    generate
        for (genvar i = 0; i < ECPSC_NFLAG; i++) begin : g_flag
            ecpsc_pend_flag u_flag (
                .clk_in(CLK_IN),
                .rst_in(SYS_RST_IN),
                .sw_set_in(sw_set[i]),
                .hw_set_in(hw_set[i]),
                .sw_clr_in(sw_clr[i]), // [R12]
                .entry_clr_in(entry_clr[i]),
                .pend_out(pend_w[i])
            );
        end
    endgenerate

    assign DEFERRED_PEND_OUT = pend_w[ECPSC_IDX_DEF];
    assign TICK_PEND_OUT = pend_w[ECPSC_IDX_TICK];

    // ------------------------------------------------------------
    // status bits
    // ------------------------------------------------------------
    // one cycle of lag on both bits; reads see the previous cycle
    ecpsc_status u_status (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .debug_halted_in(DEBUG_HALTED_IN),
        .halt_irq_ready_in(HALT_IRQ_READY_IN),
        .ext_irq_pend_in(EXT_IRQ_PEND_IN),
        .def_pend_in(pend_w[ECPSC_IDX_DEF]),
        .tick_pend_in(pend_w[ECPSC_IDX_TICK]),
        .halt_irq_out(halt_irq_w),
        .any_pend_out(any_pend_w)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DEF_SET: assert property (@(posedge CLK_IN) // [R01]
        disable iff (SYS_RST_IN)
        wr_take && AVS_WRITEDATA_IN[ECPSC_DEF_SET_BIT] |=> DEFERRED_PEND_OUT)
        else $error("deferred set write did not set pending");

    AST_DEF_ONLY_SW: assert property (@(posedge CLK_IN) // [R02]
        disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) && $rose(DEFERRED_PEND_OUT) |->
        $past(wr_take) && $past(AVS_WRITEDATA_IN[ECPSC_DEF_SET_BIT]))
        else $error("deferred pending rose without a set write");

    AST_DEF_CLR: assert property (@(posedge CLK_IN) // [R03]
        disable iff (SYS_RST_IN)
        sw_clr[ECPSC_IDX_DEF] && !sw_set[ECPSC_IDX_DEF] |=>
        !DEFERRED_PEND_OUT)
        else $error("deferred clear write did not clear");

    AST_DEF_ZERO_KEEPS: assert property (@(posedge CLK_IN) // [R03]
        disable iff (SYS_RST_IN)
        wr_take && !AVS_WRITEDATA_IN[ECPSC_DEF_CLR_BIT] &&
        !DEFERRED_ENTRY_IN && DEFERRED_PEND_OUT |=> DEFERRED_PEND_OUT)
        else $error("zero clear bit dropped deferred pending");

    AST_CLR_RD_ZERO: assert property (@(posedge CLK_IN) // [R04]
        disable iff (SYS_RST_IN)
        state_r == ECPSC_ST_ACK |->
        !AVS_READDATA_OUT[ECPSC_DEF_CLR_BIT] &&
        !AVS_READDATA_OUT[ECPSC_TICK_CLR_BIT])
        else $error("clear bit read back nonzero");

    AST_TICK_SET: assert property (@(posedge CLK_IN) // [R05]
        disable iff (SYS_RST_IN)
        sw_set[ECPSC_IDX_TICK] |=> TICK_PEND_OUT)
        else $error("tick set write did not set pending");

    AST_TICK_EVENT: assert property (@(posedge CLK_IN) // [R05]
        disable iff (SYS_RST_IN)
        TICK_EVENT_IN |=> TICK_PEND_OUT)
        else $error("tick event did not set pending");

    AST_RD_PEND: assert property (@(posedge CLK_IN) // [R01] [R05]
        disable iff (SYS_RST_IN)
        state_r == ECPSC_ST_ACK && $past(AVS_READ_IN) &&
        $past(AVS_ADDRESS_IN) == ECPSC_ICS_OFFSET |->
        AVS_READDATA_OUT[ECPSC_DEF_SET_BIT] == $past(DEFERRED_PEND_OUT) &&
        AVS_READDATA_OUT[ECPSC_TICK_SET_BIT] == $past(TICK_PEND_OUT))
        else $error("read word does not show pending state");

    AST_TICK_CLR: assert property (@(posedge CLK_IN) // [R06] [R07]
        disable iff (SYS_RST_IN)
        wr_take && AVS_WRITEDATA_IN[ECPSC_TICK_CLR_BIT] &&
        !AVS_WRITEDATA_IN[ECPSC_TICK_SET_BIT] && !TICK_EVENT_IN |=>
        !TICK_PEND_OUT)
        else $error("tick clear write did not clear");

    AST_ZERO_KEEPS: assert property (@(posedge CLK_IN) // [R07]
        disable iff (SYS_RST_IN)
        wr_take && !AVS_WRITEDATA_IN[ECPSC_TICK_CLR_BIT] &&
        !TICK_ENTRY_IN && TICK_PEND_OUT |=> TICK_PEND_OUT)
        else $error("zero clear bit dropped tick pending");

    AST_HALT_FOLLOW: assert property (@(posedge CLK_IN) // [R08]
        disable iff (SYS_RST_IN)
        DEBUG_HALTED_IN && HALT_IRQ_READY_IN |=> halt_irq_w)
        else $error("halt release status not shown");

    AST_HALT_ZERO: assert property (@(posedge CLK_IN) // [R09]
        disable iff (SYS_RST_IN)
        !DEBUG_HALTED_IN |=> !halt_irq_w)
        else $error("halt release status set outside debug");

    AST_ANY_PEND: assert property (@(posedge CLK_IN) // [R10]
        disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) |-> any_pend_w == ($past(EXT_IRQ_PEND_IN) ||
        $past(pend_w[ECPSC_IDX_DEF]) || $past(pend_w[ECPSC_IDX_TICK])))
        else $error("global pending status wrong");

    AST_RSV_ZERO: assert property (@(posedge CLK_IN) // [R11]
        disable iff (SYS_RST_IN)
        state_r == ECPSC_ST_ACK |-> !AVS_READDATA_OUT[ECPSC_RSV_HI_BIT] &&
        AVS_READDATA_OUT[ECPSC_RSV_LO_MSB:ECPSC_RSV_LO_LSB] == 4'h0)
        else $error("reserved bits read nonzero");

    AST_ENTRY_CLR: assert property (@(posedge CLK_IN) // [R13]
        disable iff (SYS_RST_IN)
        TICK_ENTRY_IN && !sw_set[ECPSC_IDX_TICK] && !TICK_EVENT_IN |=>
        !TICK_PEND_OUT)
        else $error("handler entry did not clear tick pending");

    AST_DEF_ENTRY_CLR: assert property (@(posedge CLK_IN) // [R13]
        disable iff (SYS_RST_IN)
        DEFERRED_ENTRY_IN && !sw_set[ECPSC_IDX_DEF] |=> !DEFERRED_PEND_OUT)
        else $error("handler entry did not clear deferred pending");

    AST_WAIT_BOUND: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        state_r == ECPSC_ST_IDLE && (AVS_READ_IN || AVS_WRITE_IN) |=>
        !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
        else $error("waitrequest not low for exactly one cycle");

    AST_RD_IDLE_ZERO: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        state_r != ECPSC_ST_ACK |-> AVS_READDATA_OUT == ECPSC_UNMAPPED_RD)
        else $error("read data not idle outside the answer cycle");

endmodule : ecpsc_top

// ### test/ecpsc_core_model.sv
// behavioural model of the core exception entry logic
// assumes the bench drives its controls right after a rising clock edge
`timescale 1ns/1ps
module ecpsc_core_model
    import ecpsc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // bench control
    input wire logic tick_req_in,
    input wire logic entry_en_in,
    input wire logic [1:0] lat_in,
    // pending state from the block
    input wire logic def_pend_in,
    input wire logic tick_pend_in,
    // strobes to the block
    output logic tick_event_out,
    output logic def_entry_out,
    output logic tick_entry_out
);
    logic [1:0] wait_r;
    // ------------------------------------------------------------
    // handler entry
    // ------------------------------------------------------------
    // entry follows lat_in cycles of seen pending; the bench enables entry
    // only with lat_in at 2, a slow core; one strobe per handler entry
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wait_r <= 2'h0;
            tick_event_out <= 1'b0;
            def_entry_out <= 1'b0;
            tick_entry_out <= 1'b0;
        end else begin
            tick_event_out <= tick_req_in;
            def_entry_out <= 1'b0;
            tick_entry_out <= 1'b0;
            if (!entry_en_in || !(def_pend_in || tick_pend_in) ||
                def_entry_out || tick_entry_out) begin
                wait_r <= 2'h0;
            end else if (wait_r < lat_in) begin
                wait_r <= wait_r + 2'h1;
            end else if (def_pend_in) begin
                def_entry_out <= 1'b1;
            end else begin
                tick_entry_out <= 1'b1;
            end
        end
    end
endmodule : ecpsc_core_model

// ### test/exception_pend_set_clear_status_test.sv
// self-checking bench for the exception pend set/clear/status slice
// assumes the core model sits on the pending outputs of the block
`timescale 1ns/1ps
module exception_pend_set_clear_status_test
    import ecpsc_pkg::*;
;
    localparam logic [31:0] RD_MASK = 32'hf5ff_ffff;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, q, d;
    logic [31:0] lfsr_s = 32'h2dac6e02;
    logic [3:0] be = 4'h0;
    logic wrq, tick_ev, def_ent, tick_ent, def_p, tick_p;
    logic dbg = 1'b0, hrdy = 1'b0, ext = 1'b0;
    logic tick_req = 1'b0, ent_en = 1'b0;
    logic [1:0] lat = 2'h0;
    int n_mismatch = 0, check_count = 0, cyc = 0, m_def = 0, m_tick = 0;

    always #4 clk = ~clk;

    ecpsc_top dut (.CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wrq), .DEBUG_HALTED_IN(dbg),
        .HALT_IRQ_READY_IN(hrdy), .EXT_IRQ_PEND_IN(ext),
        .TICK_EVENT_IN(tick_ev), .DEFERRED_ENTRY_IN(def_ent),
        .TICK_ENTRY_IN(tick_ent), .DEFERRED_PEND_OUT(def_p),
        .TICK_PEND_OUT(tick_p));

    ecpsc_core_model core (.clk_in(clk), .rst_in(rst), .tick_req_in(tick_req),
        .entry_en_in(ent_en), .lat_in(lat), .def_pend_in(def_p),
        .tick_pend_in(tick_p), .tick_event_out(tick_ev),
        .def_entry_out(def_ent), .tick_entry_out(tick_ent));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction : lfsr

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string m);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    // one avalon access; sampled values are those before the edge
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] dd, input logic [3:0] b, output logic [31:0] r);
        int n;
        n = 0;
        addr <= a;
        wdata <= dd;
        be <= b;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wrq !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        r = rdata;
        // the slave answers every access after exactly one wait cycle
        chk(n, 32'd1, "wait cycles");
        wr <= 1'b0;
        rd <= 1'b0;
        // idle edge lets the one-cycle status lag settle before a read
        @(posedge clk);
    endtask : bus

    task automatic wr_reg(input logic [31:0] dd, input logic [3:0] b);
        bus(1'b1, ECPSC_ICS_OFFSET, dd, b, q);
        if (b[ECPSC_CTRL_LANE]) begin
            if (dd[28]) m_def = 1; else if (dd[27]) m_def = 0;
            if (dd[26]) m_tick = 1; else if (dd[25]) m_tick = 0;
        end
    endtask : wr_reg

    // clear bits read undefined, so they are masked off
    task automatic rd_chk(input string m);
        logic [31:0] e;
        e = 32'(m_def << 28) | 32'(m_tick << 26) | 32'(dbg & hrdy) << 23 |
            32'(ext || m_def != 0 || m_tick != 0) << 22;
        bus(1'b0, ECPSC_ICS_OFFSET, 32'h0, 4'hf, q);
        chk(q & RD_MASK, e, m);
        chk({30'h0, def_p, tick_p}, 32'(m_def << 1 | m_tick), m);
    endtask : rd_chk

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        int k;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk("reset word");
        wr_reg(32'h1000_0000, 4'hf);
        rd_chk("deferred set");
        wr_reg(32'h0, 4'hf);
        rd_chk("write zero");
        wr_reg(32'h0800_0000, 4'hf);
        rd_chk("deferred clear");
        wr_reg(32'h0400_0000, 4'hf);
        rd_chk("tick set");
        wr_reg(32'h0200_0000, 4'hf);
        rd_chk("tick clear");
        $display("test sw set clear done");
        wr_reg(32'h1400_0000, 4'h7);
        rd_chk("lane 3 off");
        bus(1'b1, 12'h000, 32'h1400_0000, 4'hf, q);
        rd_chk("unmapped write");
        bus(1'b0, 12'hd08, 32'h0, 4'hf, q);
        chk(q, ECPSC_UNMAPPED_RD, "unmapped read");
        // no set bit is sent together with its own clear bit
        wr_reg(32'h113c_ffff, 4'hf);
        rd_chk("reserved bits");
        $display("test refused access done");
        tick_req <= 1'b1;
        @(posedge clk);
        tick_req <= 1'b0;
        repeat (3) @(posedge clk);
        m_tick = 1;
        rd_chk("tick event");
        lat <= 2'h2;
        ent_en <= 1'b1;
        k = 0;
        while ((def_p !== 1'b0 || tick_p !== 1'b0) && k < 40) begin
            @(posedge clk);
            k++;
        end
        ent_en <= 1'b0;
        m_def = 0;
        m_tick = 0;
        rd_chk("handler entry");
        $display("test core strobes done");
        for (int i = 0; i < 8; i++) begin
            {dbg, hrdy, ext} <= i[2:0];
            repeat (3) @(posedge clk);
            rd_chk("status bits");
        end
        $display("test status done");
        for (int i = 0; i < 30; i++) begin
            lfsr_s = lfsr(lfsr_s);
            d = lfsr_s;
            // set together with its own clear is never sent
            if (d[28]) d[27] = 1'b0;
            if (d[26]) d[25] = 1'b0;
            {dbg, hrdy, ext} <= lfsr_s[10:8];
            lat <= lfsr_s[13:12];
            wr_reg(d, lfsr_s[7:4]);
            rd_chk("random access");
        end
        $display("test random done");
        final_report();
    end
endmodule : exception_pend_set_clear_status_test
